/* src/dsdfb_pkg.sv */
// Constants and types shared by both ends of the diagnostic frame link.
package dsdfb_pkg;

  // Frame geometry in bytes.
  localparam logic [7:0]  HDR_LEN      = 8'h06;
  localparam logic [7:0]  EXT_MAX      = 8'hee;
  localparam logic [7:0]  FRAME_MAX    = 8'hf4;
  localparam logic [7:0]  USER_TAG     = 8'h08;

  // Request addressing.
  localparam logic [15:0] IDX_GROUP    = 16'hf481;
  localparam logic [15:0] IDX_OFFSET   = 16'h0000;
  localparam logic [15:0] PORT_BASE    = 16'h1000;

  // Header byte positions.
  localparam int          HB_STAT0     = 0;
  localparam int          HB_STAT1     = 1;
  localparam int          HB_STAT2     = 2;
  localparam int          HB_OWNER     = 3;
  localparam int          HB_IDENT_HI  = 4;
  localparam int          HB_IDENT_LO  = 5;

  // Bit positions in status byte zero.
  localparam int          S0_ABSENT    = 0;
  localparam int          S0_BUSY      = 1;
  localparam int          S0_CFG_FAULT = 2;
  localparam int          S0_EXT_INFO  = 3;
  localparam int          S0_UNSUPP    = 4;
  localparam int          S0_BAD_RESP  = 5;
  localparam int          S0_PRM_FAULT = 6;
  localparam int          S0_FOREIGN   = 7;

  // Bit positions in status bytes one and two.
  localparam int          S1_REPARAM   = 0;
  localparam int          S1_STATIC    = 1;
  localparam int          S1_DP_SLAVE  = 2;
  localparam int          S1_WATCHDOG  = 3;
  localparam int          S1_FREEZE    = 4;
  localparam int          S1_SYNC      = 5;
  localparam int          S1_DEACT     = 7;
  localparam int          S2_OVERFLOW  = 7;

  // Extended block header: length field width.
  localparam int          BLK_LEN_W    = 6;

  typedef enum logic [1:0] {DS_IDLE, DS_WRITE, DS_DROP, DS_READ} dsdfb_dev_state_t;
  typedef enum logic [2:0] {AS_IDLE, AS_TAG, AS_PAD, AS_BODY, AS_SKIP, AS_REQ, AS_READ}
    dsdfb_app_state_t;

endpackage : dsdfb_pkg

/* src/dsdfb_if.sv */
// Link between the diagnostic frame builder and the application end.
`timescale 1ns/100ps
interface dsdfb_if;
  logic [15:0] req_group;
  logic [15:0] req_offset;
  logic [15:0] req_port;
  logic        wr_valid;
  logic        wr_ready;
  logic [7:0]  wr_data;
  logic        wr_last;
  logic        rd_req_valid;
  logic        rd_req_ready;
  logic        rd_valid;
  logic        rd_ready;
  logic [7:0]  rd_data;
  logic        rd_last;
  logic        diag_pending;
  logic        req_error;

  modport dev (
    input  req_group, req_offset, req_port, wr_valid, wr_data, wr_last,
    input  rd_req_valid, rd_ready,
    output wr_ready, rd_req_ready, rd_valid, rd_data, rd_last, diag_pending, req_error
  );

  modport app (
    output req_group, req_offset, req_port, wr_valid, wr_data, wr_last,
    output rd_req_valid, rd_ready,
    input  wr_ready, rd_req_ready, rd_valid, rd_data, rd_last, diag_pending, req_error
  );
endinterface : dsdfb_if

/* src/dsdfb_dev.sv */
// Diagnostic frame builder: the slave end that stores, frames and returns diagnostics.
// Summary of operation
// - Frame is six header bytes plus 238 extended.
// - Content change raises pending; master fetches later.
// - Byte0 bits0-2: absent, busy, config fault.
// - Extended valid in byte0.3; overflow in byte2.7.
// - Byte0 bits4-7: unsupported, bad reply, param, foreign.
// - Byte1 bits0-1: reparameterize request, static diagnosis.
// - Byte1.2 marks DP slave; byte1.3 watchdog.
// - Byte1 bits4,5,7: freeze, sync, deactivated.
// - Byte3 owner address; bytes4-5 device identifier.
// - Writer puts tag 0x08 in first byte.
// - Written bytes one to five are replaced.
// - User content from byte six passes unchanged.
// - Write uses fixed group, offset zero, derived port.
// - Read returns the sent frame with header.
// - Extended blocks start with length/type header byte.
`timescale 1ns/100ps
module dsdfb_dev
  import dsdfb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  dsdfb_if.dev             lnk,
  input  wire logic        station_absent_flag,
  input  wire logic        station_busy_flag,
  input  wire logic        config_fault_flag,
  input  wire logic        unsupported_feature_flag,
  input  wire logic        bad_response_flag,
  input  wire logic        param_fault_flag,
  input  wire logic        foreign_owner_flag,
  input  wire logic        reparam_request_flag,
  input  wire logic        static_diag_flag,
  input  wire logic        watchdog_active_flag,
  input  wire logic        input_freeze_state,
  input  wire logic        output_sync_state,
  input  wire logic        station_deactivated_flag,
  input  wire logic [7:0]  owner_station_address,
  input  wire logic [15:0] device_identifier,
  input  wire logic [7:0]  slave_address,
  output logic             extended_info_flag,
  output logic             extended_overflow_flag,
  output logic [7:0]       ext_length
);

  dsdfb_dev_state_t state_q, state_d;
  logic [7:0]  mem_q [EXT_MAX];
  logic [7:0]  mem_d [EXT_MAX];
  logic [7:0]  hdr_live [HDR_LEN];
  logic [7:0]  hdr_q [HDR_LEN];
  logic [7:0]  hdr_d [HDR_LEN];
  logic [47:0] seen_q, seen_d, live_flat;
  logic [7:0]  widx_q, widx_d, ridx_q, ridx_d, next_idx, total;
  logic [8:0]  nhdr_q, nhdr_d;
  logic        blk_ok_q, blk_ok_d, ovf_q, ovf_d;
  logic [7:0]  ext_len_q, ext_len_d;
  logic        ext_ok_q, ext_ok_d, ext_ovf_q, ext_ovf_d;
  logic        pend_q, pend_d, err_q, err_d;
  logic        commit, read_start, addr_ok, wr_hs, push, pop;
  logic [7:0]  frame_byte;
  logic [7:0]  fifo_data_q [2];
  logic [7:0]  fifo_data_d [2];
  logic [1:0]  fifo_last_q, fifo_last_d;
  logic        wptr_q, wptr_d, rptr_q, rptr_d;
  logic [1:0]  cnt_q, cnt_d;

  // Live header; the reserved bits are left at zero.
  always_comb
  begin
    hdr_live = '{default: 8'h00};
    hdr_live[HB_STAT0][S0_ABSENT]    = station_absent_flag;
    hdr_live[HB_STAT0][S0_BUSY]      = station_busy_flag;
    hdr_live[HB_STAT0][S0_CFG_FAULT] = config_fault_flag;
    hdr_live[HB_STAT0][S0_EXT_INFO]  = ext_ok_q;
    hdr_live[HB_STAT0][S0_UNSUPP]    = unsupported_feature_flag;
    hdr_live[HB_STAT0][S0_BAD_RESP]  = bad_response_flag;
    hdr_live[HB_STAT0][S0_PRM_FAULT] = param_fault_flag;
    hdr_live[HB_STAT0][S0_FOREIGN]   = foreign_owner_flag;
    hdr_live[HB_STAT1][S1_REPARAM]   = reparam_request_flag;
    hdr_live[HB_STAT1][S1_STATIC]    = static_diag_flag;
    hdr_live[HB_STAT1][S1_DP_SLAVE]  = 1'b1;
    hdr_live[HB_STAT1][S1_WATCHDOG]  = watchdog_active_flag;
    hdr_live[HB_STAT1][S1_FREEZE]    = input_freeze_state;
    hdr_live[HB_STAT1][S1_SYNC]      = output_sync_state;
    hdr_live[HB_STAT1][S1_DEACT]     = station_deactivated_flag;
    hdr_live[HB_STAT2][S2_OVERFLOW]  = ext_ovf_q;
    hdr_live[HB_OWNER]               = owner_station_address;
    hdr_live[HB_IDENT_HI]            = device_identifier[15:8];
    hdr_live[HB_IDENT_LO]            = device_identifier[7:0];
  end

  assign live_flat = {hdr_live[0], hdr_live[1], hdr_live[2],
                      hdr_live[3], hdr_live[4], hdr_live[5]};
  assign addr_ok   = (lnk.req_group == IDX_GROUP) && (lnk.req_offset == IDX_OFFSET)
                   && (lnk.req_port == PORT_BASE + {8'h00, slave_address});
  assign wr_hs     = lnk.wr_valid && lnk.wr_ready;
  assign total     = HDR_LEN + ext_len_q;
  assign next_idx  = (widx_q == FRAME_MAX) ? FRAME_MAX : widx_q + 8'h01;
  assign push      = (state_q == DS_READ) && (cnt_q != 2'h2);
  assign pop       = lnk.rd_valid && lnk.rd_ready;
  assign frame_byte = (ridx_q < HDR_LEN) ? hdr_q[ridx_q[2:0]]
                                         : mem_q[ridx_q - HDR_LEN];

  // Writes are taken whenever no read is in progress, so a frame leaves intact.
  assign lnk.wr_ready     = (state_q != DS_READ);
  assign lnk.rd_req_ready = (state_q == DS_IDLE) && !lnk.wr_valid;

  always_comb
  begin
    state_d    = state_q;
    mem_d      = mem_q;
    hdr_d      = hdr_q;
    widx_d     = widx_q;
    ridx_d     = ridx_q;
    nhdr_d     = nhdr_q;
    blk_ok_d   = blk_ok_q;
    ovf_d      = ovf_q;
    ext_len_d  = ext_len_q;
    ext_ok_d   = ext_ok_q;
    ext_ovf_d  = ext_ovf_q;
    err_d      = 1'b0;
    commit     = 1'b0;
    read_start = 1'b0;
    case (state_q)
      DS_IDLE:
      begin
        if (wr_hs)
        begin
          if (addr_ok && lnk.wr_data == USER_TAG)
          begin
            widx_d   = 8'h01;
            nhdr_d   = {1'b0, HDR_LEN};
            blk_ok_d = 1'b1;
            ovf_d    = 1'b0;
            state_d  = lnk.wr_last ? DS_IDLE : DS_WRITE;
            if (lnk.wr_last)
            begin
              ext_len_d = 8'h00;
              ext_ok_d  = 1'b0;
              ext_ovf_d = 1'b0;
              commit    = 1'b1;
            end
          end
          else
          begin
            err_d   = 1'b1;
            state_d = lnk.wr_last ? DS_IDLE : DS_DROP;
          end
        end
        else if (lnk.rd_req_valid)
        begin
          err_d = !addr_ok;
          if (addr_ok)
          begin
            hdr_d      = hdr_live;
            ridx_d     = 8'h00;
            read_start = 1'b1;
            state_d    = DS_READ;
          end
        end
      end
      DS_WRITE:
      begin
        if (wr_hs)
        begin
          // Bytes one to five carry nothing: the header is built from live status.
          if (widx_q >= HDR_LEN)
          begin
            if (widx_q < FRAME_MAX)
            begin
              mem_d[widx_q - HDR_LEN] = lnk.wr_data;
              if ({1'b0, widx_q} == nhdr_q)
              begin
                // A zero length would never advance, so it spoils the whole chain.
                blk_ok_d = blk_ok_q && (lnk.wr_data[BLK_LEN_W-1:0] != '0);
                nhdr_d   = nhdr_q + {3'h0, lnk.wr_data[BLK_LEN_W-1:0]};
              end
            end
            else
              ovf_d = 1'b1;
          end
          widx_d = next_idx;
          if (lnk.wr_last)
          begin
            ext_len_d = (next_idx > HDR_LEN) ? next_idx - HDR_LEN : 8'h00;
            // Unless the write overflowed, a block chain that does not close exactly marks the area invalid.
            ext_ok_d  = (next_idx > HDR_LEN) && blk_ok_d
                        && (ovf_d || nhdr_d == {1'b0, next_idx});
            ext_ovf_d = ovf_d;
            commit    = 1'b1;
            state_d   = DS_IDLE;
          end
        end
      end
      DS_DROP:
        if (wr_hs && lnk.wr_last)
          state_d = DS_IDLE;
      DS_READ:
        if (push)
        begin
          ridx_d = ridx_q + 8'h01;
          if (ridx_q == total - 8'h01)
            state_d = DS_IDLE;
        end
      default:
        state_d = DS_IDLE;
    endcase
    seen_d = live_flat;
    // A new change wins over the clear made by a fetch in the same cycle.
    pend_d = (live_flat != seen_q) || commit || (pend_q && !read_start);
  end

  // Two-entry output buffer so a stalled reader loses no byte.
  always_comb
  begin
    fifo_data_d = fifo_data_q;
    fifo_last_d = fifo_last_q;
    wptr_d      = wptr_q;
    rptr_d      = rptr_q;
    if (push)
    begin
      fifo_data_d[wptr_q] = frame_byte;
      fifo_last_d[wptr_q] = (ridx_q == total - 8'h01);
      wptr_d              = ~wptr_q;
    end
    if (pop)
      rptr_d = ~rptr_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  assign lnk.rd_valid     = (cnt_q != 2'h0);
  assign lnk.rd_data      = fifo_data_q[rptr_q];
  assign lnk.rd_last      = fifo_last_q[rptr_q];
  assign lnk.diag_pending = pend_q;
  assign lnk.req_error    = err_q;
  assign extended_info_flag     = ext_ok_q;
  assign extended_overflow_flag = ext_ovf_q;
  assign ext_length             = ext_len_q;

  always_ff @(posedge clock)
    if (!rst_n)
    begin
      state_q                                <= DS_IDLE;
      {widx_q, ridx_q, ext_len_q}            <= 24'h000000;
      nhdr_q                                 <= 9'h000;
      {blk_ok_q, ovf_q, ext_ok_q, ext_ovf_q} <= 4'h0;
      {pend_q, err_q, wptr_q, rptr_q}        <= 4'h0;
      {fifo_last_q, cnt_q}                   <= 4'h0;
      seen_q                                 <= 48'h000000000000;
      mem_q                                  <= '{default: 8'h00};
      hdr_q                                  <= '{default: 8'h00};
      fifo_data_q                            <= '{default: 8'h00};
    end
    else
    begin
      state_q                                <= state_d;
      mem_q                                  <= mem_d;
      hdr_q                                  <= hdr_d;
      {widx_q, ridx_q, ext_len_q}            <= {widx_d, ridx_d, ext_len_d};
      nhdr_q                                 <= nhdr_d;
      {blk_ok_q, ovf_q, ext_ok_q, ext_ovf_q} <= {blk_ok_d, ovf_d, ext_ok_d, ext_ovf_d};
      {pend_q, err_q, wptr_q, rptr_q}        <= {pend_d, err_d, wptr_d, rptr_d};
      seen_q                                 <= seen_d;
      fifo_data_q                            <= fifo_data_d;
      fifo_last_q                            <= fifo_last_d;
      cnt_q                                  <= cnt_d;
    end

endmodule : dsdfb_dev

/* src/dsdfb_app.sv */
// Application end: delivers user diagnostics and fetches the frame on change.
`timescale 1ns/100ps
module dsdfb_app
  import dsdfb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  dsdfb_if.app            lnk,
  input  wire logic [7:0] slave_address,
  input  wire logic       usr_wr_valid,
  output logic            usr_wr_ready,
  input  wire logic [7:0] usr_wr_data,
  input  wire logic       usr_wr_last,
  input  wire logic       usr_fetch,
  output logic            usr_rd_valid,
  input  wire logic       usr_rd_ready,
  output logic [7:0]      usr_rd_data,
  output logic            usr_rd_last,
  output logic            usr_trunc,
  output logic            usr_error
);

  dsdfb_app_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic       trunc_q, trunc_d, err_q, err_d;
  logic       cap;

  assign lnk.req_group  = IDX_GROUP;
  assign lnk.req_offset = IDX_OFFSET;
  assign lnk.req_port   = PORT_BASE + {8'h00, slave_address};

  // The last byte that still fits the frame closes the write early.
  assign cap = (cnt_q == FRAME_MAX - 8'h01);

  always_comb
  begin
    state_d          = state_q;
    cnt_d            = cnt_q;
    trunc_d          = 1'b0;
    err_d            = lnk.req_error;
    lnk.wr_valid     = 1'b0;
    lnk.wr_data      = 8'h00;
    lnk.wr_last      = 1'b0;
    lnk.rd_req_valid = 1'b0;
    lnk.rd_ready     = 1'b0;
    usr_wr_ready     = 1'b0;
    usr_rd_valid     = 1'b0;
    usr_rd_data      = lnk.rd_data;
    usr_rd_last      = lnk.rd_last;
    case (state_q)
      AS_IDLE:
      begin
        if (usr_wr_valid)
        begin
          state_d = AS_TAG;
        end
        else if (lnk.diag_pending || usr_fetch)
        begin
          state_d = AS_REQ;
        end
      end
      AS_TAG:
      begin
        lnk.wr_valid = 1'b1;
        lnk.wr_data  = USER_TAG;
        if (lnk.wr_ready)
        begin
          cnt_d   = 8'h01;
          state_d = AS_PAD;
        end
      end
      AS_PAD:
      begin
        // Filler for bytes the slave overwrites with its own status.
        lnk.wr_valid = 1'b1;
        if (lnk.wr_ready)
        begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == HDR_LEN - 8'h01)
          begin
            state_d = AS_BODY;
          end
        end
      end
      AS_BODY:
      begin
        lnk.wr_valid = usr_wr_valid;
        lnk.wr_data  = usr_wr_data;
        lnk.wr_last  = usr_wr_last || cap;
        usr_wr_ready = lnk.wr_ready;
        if (usr_wr_valid && lnk.wr_ready)
        begin
          cnt_d = cnt_q + 8'h01;
          if (usr_wr_last)
          begin
            state_d = AS_IDLE;
          end
          else if (cap)
          begin
            trunc_d = 1'b1;
            state_d = AS_SKIP;
          end
        end
      end
      AS_SKIP:
      begin
        usr_wr_ready = 1'b1;
        if (usr_wr_valid && usr_wr_last)
        begin
          state_d = AS_IDLE;
        end
      end
      AS_REQ:
      begin
        lnk.rd_req_valid = 1'b1;
        if (lnk.rd_req_ready)
        begin
          state_d = AS_READ;
        end
        else if (lnk.req_error)
        begin
          state_d = AS_IDLE;
        end
      end
      AS_READ:
      begin
        usr_rd_valid = lnk.rd_valid;
        lnk.rd_ready = usr_rd_ready;
        if (lnk.rd_valid && usr_rd_ready && lnk.rd_last)
        begin
          state_d = AS_IDLE;
        end
      end
      default:
      begin
        state_d = AS_IDLE;
      end
    endcase
  end

  assign usr_trunc = trunc_q;
  assign usr_error = err_q;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= AS_IDLE;
      cnt_q   <= 8'h00;
      trunc_q <= 1'b0;
      err_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trunc_q <= trunc_d;
      err_q   <= err_d;
    end
  end

endmodule : dsdfb_app

/* tb/dsdfb_monitor.sv */
// Checker for the link between the diagnostic frame builder and the application end.
`timescale 1ns/100ps
module dsdfb_monitor
  import dsdfb_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [15:0] req_group,
  input wire logic [15:0] req_offset,
  input wire logic [15:0] req_port,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_last,
  input wire logic        rd_req_valid,
  input wire logic        rd_req_ready,
  input wire logic        rd_valid,
  input wire logic        rd_ready,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_last,
  input wire logic        diag_pending,
  input wire logic        req_error
);
  logic       wr_mid_q;
  logic [7:0] rd_idx_q;

  // Stream positions let header bytes be told apart from body bytes.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_mid_q <= 1'b0;
      rd_idx_q <= 8'h00;
    end
    else
    begin
      if (wr_valid && wr_ready)
        wr_mid_q <= !wr_last;
      if (rd_valid && rd_ready)
        rd_idx_q <= rd_last ? 8'h00 : rd_idx_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_addr;
    (wr_valid || rd_req_valid) |-> req_group == IDX_GROUP && req_offset == IDX_OFFSET
      && req_port[15:8] == PORT_BASE[15:8];
  endproperty
  a_addr: assert property (p_addr) else $error("bad request address");
  property p_tag;
    wr_valid && wr_ready && !wr_mid_q |-> wr_data == USER_TAG;
  endproperty
  a_tag: assert property (p_tag) else $error("first write byte wrong");
  property p_pend;
    wr_valid && wr_ready && wr_last && wr_mid_q |=> diag_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("no pending after write");
  property p_start;
    rd_req_valid && rd_req_ready |-> ##[1:2] rd_valid;
  endproperty
  a_start: assert property (p_start) else $error("read answer late");
  property p_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data) && $stable(rd_last);
  endproperty
  a_hold: assert property (p_hold) else $error("read byte lost in stall");
  property p_slave;
    rd_valid && rd_idx_q == 8'h01 |-> rd_data[S1_DP_SLAVE] && !rd_data[6];
  endproperty
  a_slave: assert property (p_slave) else $error("status byte one wrong");
  property p_resv;
    rd_valid && rd_idx_q == 8'h02 |-> rd_data[6:0] == 7'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_len;
    rd_valid && rd_ready && rd_last |-> rd_idx_q >= 8'h05 && rd_idx_q <= 8'hf3;
  endproperty
  a_len: assert property (p_len) else $error("frame length out of range");
  property p_err;
    req_error |=> !req_error;
  endproperty
  a_err: assert property (p_err) else $error("error longer than a pulse");

  c_commit: cover property (wr_valid && wr_ready && wr_last && wr_mid_q);
  c_stall: cover property (rd_valid && !rd_ready);
  c_frame: cover property (rd_valid && rd_ready && rd_last && rd_idx_q > 8'h05);
endmodule : dsdfb_monitor

/* tb/dsdfb_tb.sv */
// Self-checking bench for the diagnostic frame builder and its application end.
`timescale 1ns/100ps
module dsdfb_tb
  import dsdfb_pkg::*;
;
  typedef struct packed
  {
    logic [12:0] flags;
    logic [7:0]  owner;
    logic [15:0] ident;
    logic [7:0]  b0;
    logic [7:0]  b1;
  } dsdfb_row_t;

  logic        clock, rst_n, stall, usr_error, ext_info, ext_ovf;
  logic        trunc_seen = 1'b0, bad_seen = 1'b0;
  logic        usr_wr_valid, usr_wr_ready, usr_wr_last, usr_fetch;
  logic        usr_rd_valid, usr_rd_ready, usr_rd_last, usr_trunc;
  logic [12:0] f;
  logic [7:0]  ow, sa, usr_wr_data, usr_rd_data, ext_len;
  logic [15:0] id;
  logic [7:0]  cur [0:255];
  logic [7:0]  fr [0:255];
  logic [7:0]  q [$];
  int          err_total, n_compared, cyc, pos, flen, nfr;
  dsdfb_row_t  rows [4] = '{'{13'h0000, 8'h01, 16'h1234, 8'h00, 8'h04},
                            '{13'h0055, 8'h7e, 16'hbeef, 8'ha5, 8'h04},
                            '{13'h0aaa, 8'h02, 16'h00ff, 8'h52, 8'h2d},
                            '{13'h1500, 8'hff, 16'ha55a, 8'h00, 8'h96}};

  dsdfb_if lnk ();
  dsdfb_dev dsdfb_dev_i (.clock(clock), .rst_n(rst_n), .lnk(lnk),
    .station_absent_flag(f[0]), .station_busy_flag(f[1]), .config_fault_flag(f[2]),
    .unsupported_feature_flag(f[3]), .bad_response_flag(f[4]), .param_fault_flag(f[5]),
    .foreign_owner_flag(f[6]), .reparam_request_flag(f[7]), .static_diag_flag(f[8]),
    .watchdog_active_flag(f[9]), .input_freeze_state(f[10]), .output_sync_state(f[11]),
    .station_deactivated_flag(f[12]), .owner_station_address(ow), .device_identifier(id),
    .slave_address(sa), .extended_info_flag(ext_info), .extended_overflow_flag(ext_ovf),
    .ext_length(ext_len));
  dsdfb_app dsdfb_app_i (.clock(clock), .rst_n(rst_n), .lnk(lnk), .slave_address(sa),
    .usr_wr_valid(usr_wr_valid), .usr_wr_ready(usr_wr_ready), .usr_wr_data(usr_wr_data),
    .usr_wr_last(usr_wr_last), .usr_fetch(usr_fetch), .usr_rd_valid(usr_rd_valid),
    .usr_rd_ready(usr_rd_ready), .usr_rd_data(usr_rd_data), .usr_rd_last(usr_rd_last),
    .usr_trunc(usr_trunc), .usr_error(usr_error));
  dsdfb_monitor dsdfb_monitor_i (.clock(clock), .rst_n(rst_n), .req_group(lnk.req_group),
    .req_offset(lnk.req_offset), .req_port(lnk.req_port), .wr_valid(lnk.wr_valid),
    .wr_ready(lnk.wr_ready), .wr_data(lnk.wr_data), .wr_last(lnk.wr_last),
    .rd_req_valid(lnk.rd_req_valid), .rd_req_ready(lnk.rd_req_ready),
    .rd_valid(lnk.rd_valid), .rd_ready(lnk.rd_ready), .rd_data(lnk.rd_data),
    .rd_last(lnk.rd_last), .diag_pending(lnk.diag_pending), .req_error(lnk.req_error));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Toggling ready halves the drain rate, so the two-entry buffer must hold back words.
  always @(negedge clock)
    usr_rd_ready <= stall ? ~usr_rd_ready : 1'b1;

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      results();
    end
    if (!rst_n)
      pos = 0;
    else
    begin
      if (usr_trunc === 1'b1)
        trunc_seen = 1'b1;
      if (usr_error !== 1'b0)
        bad_seen = 1'b1;
      if (usr_rd_valid === 1'b1 && usr_rd_ready === 1'b1)
      begin
        cur[pos] = usr_rd_data;
        pos++;
        if (usr_rd_last === 1'b1)
        begin
          fr = cur;
          flen = pos;
          pos = 0;
          nfr++;
        end
      end
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic send;
    foreach (q[i])
    begin
      @(negedge clock);
      usr_wr_valid = 1'b1;
      usr_wr_data  = q[i];
      usr_wr_last  = (i == q.size() - 1);
      #1;
      while (usr_wr_ready !== 1'b1)
      begin
        @(negedge clock);
        #1;
      end
      @(posedge clock);
    end
    @(negedge clock);
    usr_wr_valid = 1'b0;
    usr_wr_last  = 1'b0;
  endtask : send

  // Automatic fetches may carry a stale header, so wait for quiet and fetch afresh.
  task automatic get_frame;
    int n;
    repeat (2) @(negedge clock);
    while (!(lnk.diag_pending === 1'b0 && lnk.rd_req_ready === 1'b1 && lnk.rd_valid === 1'b0))
      @(negedge clock);
    n = nfr;
    usr_fetch = 1'b1;
    @(negedge clock);
    usr_fetch = 1'b0;
    while (nfr == n)
      @(negedge clock);
  endtask : get_frame

  task automatic chk_hdr(input logic [7:0] b0, input logic [7:0] b1, input int len);
    chk({fr[0], fr[1]}, {b0, b1});
    chk({fr[2], fr[3]}, {8'h00, ow});
    chk({fr[4], fr[5]}, id);
    chk(flen[15:0], len[15:0]);
  endtask : chk_hdr

  initial
  begin
    rst_n = 1'b0;
    stall = 1'b0;
    f = 13'h0000;
    ow = 8'h00;
    id = 16'h0000;
    sa = 8'h05;
    usr_wr_valid = 1'b0;
    usr_wr_data = 8'h00;
    usr_wr_last = 1'b0;
    usr_fetch = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    foreach (rows[r])
    begin
      f  = rows[r].flags;
      ow = rows[r].owner;
      id = rows[r].ident;
      get_frame();
      chk_hdr(rows[r].b0, rows[r].b1, 6);
    end
    stall = 1'b1;
    q = '{8'h08, 8'h43, 8'haa, 8'h55};
    q.delete(0);
    send();
    get_frame();
    chk({7'h00, ext_info, ext_len}, 16'h0103);
    chk_hdr(8'h08, 8'h96, 9);
    chk({fr[6], fr[7]}, 16'h43aa);
    chk({fr[8], 8'h00}, 16'h5500);
    q = '{8'h44, 8'h01};
    send();
    get_frame();
    chk({7'h00, ext_info, ext_len}, 16'h0002);
    chk_hdr(8'h00, 8'h96, 8);
    q.delete();
    for (int i = 0; i < 240; i++)
      q.push_back(i[7:0]);
    send();
    get_frame();
    chk({15'h0000, trunc_seen}, 16'h0001);
    chk(flen[15:0], 16'h00f4);
    chk({6'h00, ext_info, ext_ovf, ext_len}, 16'h00ee);
    chk({fr[6], fr[243]}, 16'h00ed);
    @(negedge clock);
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    chk({4'h0, ext_info, ext_ovf, lnk.rd_valid, lnk.diag_pending, ext_len}, 16'h0000);
    rst_n = 1'b1;
    get_frame();
    chk_hdr(8'h00, 8'h96, 6);
    chk({15'h0000, bad_seen}, 16'h0000);
    results();
  end
endmodule : dsdfb_tb
